/* src/dac_word_decoder.sv */
// serial command word decoder for a dual voltage-output converter
`timescale 1ns/1ns
`default_nettype none
module dac_word_decoder
   import dac_word_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sclk_link,
   input wire logic frame_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic [15:0] active_code_a,
   output logic [15:0] active_code_b,
   output logic [2:0] range_code_a,
   output logic [2:0] range_code_b,
   output logic [CODE_BITS:0] step_a,
   output logic [CODE_BITS:0] step_b,
   output logic power_up_a,
   output logic power_up_b,
   output logic tsd_enable,
   output logic clamp_enable,
   output logic clear_select
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [1:0] chan_decode(input logic [2:0] ch);
      logic [1:0] en;
      en = 2'h0;
      if (ch == CH_A) begin
         en = 2'h1;
      end else if (ch == CH_B) begin
         en = 2'h2;
      end else if (ch == CH_BOTH) begin
         en = 2'h3;
      end
      return en;
   endfunction

   function automatic logic [CODE_BITS:0] step_of(input logic [15:0] code,
                                                  input logic [2:0] rng);
      logic [CODE_BITS-1:0] top;
      top = code[15 -: CODE_BITS];
      if (rng >= RANGE_BIP_MIN) begin
         step_of = {top[CODE_BITS-1], top};
      end else begin
         step_of = {1'h0, top};
      end
   endfunction

   // ****************************************************************
   // link side
   // ****************************************************************
   logic [23:0] frame_word;
   logic full_tgl;
   logic long_flag;
   logic [23:0] rb_word_ff;
   logic [3:0] cfg_ff;

   frame_shifter u_shift (
      .sclk_link(sclk_link),
      .arst_n(arst_n),
      .frame_n(frame_n),
      .serial_data_in(serial_data_in),
      .rb_word(rb_word_ff),
      .sdo_dis(cfg_ff[CFG_SDO_DIS]),
      .frame_word(frame_word),
      .full_tgl(full_tgl),
      .long_flag(long_flag),
      .sdo_out(serial_data_out),
      .sdo_oe(serial_data_oe)
   );

   // ****************************************************************
   // crossing into the system clock
   // ****************************************************************
   logic fr_s1_ff, fr_s2_ff, fr_s3_ff;
   logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
   logic lg_s1_ff, lg_s2_ff;
   logic pending_ff;
   logic [23:0] word_ff;
   logic closed, new_word, commit;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fr_s1_ff <= 1'h1;
         fr_s2_ff <= 1'h1;
         fr_s3_ff <= 1'h1;
         tg_s1_ff <= 1'h0;
         tg_s2_ff <= 1'h0;
         tg_s3_ff <= 1'h0;
         lg_s1_ff <= 1'h0;
         lg_s2_ff <= 1'h0;
      end else begin
         fr_s1_ff <= frame_n;
         fr_s2_ff <= fr_s1_ff;
         fr_s3_ff <= fr_s2_ff;
         tg_s1_ff <= full_tgl;
         tg_s2_ff <= tg_s1_ff;
         tg_s3_ff <= tg_s2_ff;
         lg_s1_ff <= long_flag;
         lg_s2_ff <= lg_s1_ff;
      end
   end

   assign closed = fr_s2_ff & ~fr_s3_ff;
   assign new_word = tg_s2_ff ^ tg_s3_ff;
   // over-long frames are dropped too, not just short ones
   assign commit = closed & pending_ff & ~lg_s2_ff;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pending_ff <= 1'h0;
      end else if (new_word) begin
         pending_ff <= 1'h1;
      end else if (closed) begin
         pending_ff <= 1'h0;
      end
   end

   // word is settled: it changed with the toggle two edges earlier
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         word_ff <= RB_RESET;
      end else if (new_word) begin
         word_ff <= frame_word;
      end
   end

   // ****************************************************************
   // decode
   // ****************************************************************
   logic rw;
   logic [2:0] sel, ch;
   logic [15:0] data;
   logic [1:0] ch_en;
   logic wr_ok, rd_ok, is_clear, is_load, is_cfg;
   logic [1:0] code_we;
   logic [15:0] code_wdata, clr_code, held_a, held_b;

   assign rw = word_ff[BIT_RW];
   assign sel = word_ff[SEL_HI:SEL_LO];
   assign ch = word_ff[CH_HI:CH_LO];
   assign data = word_ff[DATA_W-1:0];
   assign ch_en = chan_decode(ch);
   assign wr_ok = commit & ~rw;
   assign rd_ok = commit & rw;
   assign is_clear = wr_ok && sel == SEL_CONTROL && ch == CTL_CLEAR;
   assign is_load = wr_ok && sel == SEL_CONTROL && ch == CTL_LOAD;
   assign is_cfg = wr_ok && sel == SEL_CONTROL && ch == CTL_CONFIG;
   assign clr_code = cfg_ff[CFG_CLR_SEL] ? CLR_MID_CODE : CLR_ZERO_CODE;
   assign code_we = is_clear ? 2'h3 :
                    (wr_ok && sel == SEL_CODE) ? ch_en : 2'h0;
   assign code_wdata = is_clear ? clr_code : (data & CODE_MASK);

   code_store u_store (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .we(code_we),
      .wdata(code_wdata),
      .held_a(held_a),
      .held_b(held_b)
   );

   // ****************************************************************
   // per-channel active code, range and step
   // ****************************************************************
   logic [15:0] act_ff [2];
   logic [2:0] rng_ff [2];
   logic [CODE_BITS:0] step_ff [2];
   logic [15:0] held [2];

   assign held[0] = held_a;
   assign held[1] = held_b;

   for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            act_ff[gi] <= CODE_RESET;
         end else if (is_load) begin
            act_ff[gi] <= held[gi];
         end else if (is_clear) begin
            act_ff[gi] <= clr_code;
         end
      end

      // codes 6 and 7 name no span and leave the range alone
      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            rng_ff[gi] <= RANGE_RESET;
         end else if (wr_ok && sel == SEL_RANGE && ch_en[gi] &&
                      data[2:0] <= RANGE_MAX) begin
            rng_ff[gi] <= data[2:0];
         end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            step_ff[gi] <= STEP_RESET;
         end else begin
            step_ff[gi] <= step_of(act_ff[gi], rng_ff[gi]);
         end
      end
   end

   assign active_code_a = act_ff[0];
   assign active_code_b = act_ff[1];
   assign range_code_a = rng_ff[0];
   assign range_code_b = rng_ff[1];
   assign step_a = step_ff[0];
   assign step_b = step_ff[1];

   // ****************************************************************
   // control and power words
   // ****************************************************************
   logic [15:0] pwr_ff;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg_ff <= CFG_RESET;
      end else if (is_cfg) begin
         cfg_ff <= data[3:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pwr_ff <= PWR_RESET;
      end else if (wr_ok && sel == SEL_POWER) begin
         pwr_ff <= data & PWR_MASK;
      end
   end

   assign power_up_a = pwr_ff[PWR_PU_A];
   assign power_up_b = pwr_ff[PWR_PU_B];
   assign tsd_enable = cfg_ff[CFG_TSD];
   assign clamp_enable = cfg_ff[CFG_CLAMP];
   assign clear_select = cfg_ff[CFG_CLR_SEL];

   // ****************************************************************
   // readback, shifted out during the next frame
   // ****************************************************************
   logic [15:0] rd_data;

   always_comb begin
      rd_data = 16'h0000;
      if (sel == SEL_CODE) begin
         rd_data = ch_en[0] ? held_a : (ch_en[1] ? held_b : 16'h0000);
      end else if (sel == SEL_RANGE) begin
         rd_data = {13'h0000, ch_en[0] ? rng_ff[0] : rng_ff[1]};
      end else if (sel == SEL_POWER) begin
         rd_data = pwr_ff;
      end else if (sel == SEL_CONTROL) begin
         rd_data = {12'h000, cfg_ff};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rb_word_ff <= RB_RESET;
      end else if (rd_ok) begin
         rb_word_ff <= {word_ff[23:16], rd_data};
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   AST_PARTIAL_NO_EFFECT: assert property (
      !$past(commit) |-> $stable(rng_ff[0]) && $stable(cfg_ff))
      else $error("range or config changed without a closed frame");
   AST_READ_NO_WRITE: assert property (
      rd_ok |=> $stable(cfg_ff) && $stable(pwr_ff) && $stable(held_a))
      else $error("read frame altered a register");
   AST_CODE_WRITE_A: assert property (
      wr_ok && sel == SEL_CODE && ch == CH_A
      |=> held_a == ($past(data) & CODE_MASK) && $stable(held_b))
      else $error("code write to channel A wrong");
   AST_CODE_LOW_BITS: assert property (
      (held_a & ~CODE_MASK) == 16'h0000 && (held_b & ~CODE_MASK) == 16'h0000)
      else $error("ignored low code bits were stored");
   AST_CHAN_B_ONLY: assert property (
      wr_ok && sel == SEL_CODE && ch == CH_B |=> $stable(held_a))
      else $error("channel B write touched channel A");
   AST_RANGE_BOTH: assert property (
      wr_ok && sel == SEL_RANGE && ch == CH_BOTH && data[2:0] <= RANGE_MAX
      |=> rng_ff[0] == $past(data[2:0]) && rng_ff[1] == $past(data[2:0]))
      else $error("range write to both channels wrong");
   AST_LOAD_BOTH: assert property (
      is_load |=> act_ff[0] == $past(held_a) && act_ff[1] == $past(held_b))
      else $error("load did not move both held codes");
   AST_CLEAR_CODE: assert property (
      is_clear && cfg_ff[CFG_CLR_SEL] |=> act_ff[0] == CLR_MID_CODE
      ##1 held_a == CLR_MID_CODE)
      else $error("clear did not apply the clear code");
   AST_BIP_STEPS: assert property (
      rng_ff[0] >= RANGE_BIP_MIN && act_ff[0] == CLR_MID_CODE
      |=> step_ff[0] == STEP_BIP_BOT)
      else $error("bipolar bottom code step wrong");
   AST_UNI_STEPS: assert property (
      rng_ff[1] < RANGE_BIP_MIN && act_ff[1] == CODE_MASK
      |=> step_ff[1] == STEP_UNI_TOP)
      else $error("unipolar top code step wrong");
   AST_READBACK_RANGE: assert property (
      rd_ok && sel == SEL_RANGE && ch == CH_A
      |=> rb_word_ff[2:0] == $past(rng_ff[0]))
      else $error("range readback wrong");

endmodule
`default_nettype wire

/* src/dac_word_pkg.sv */
// shared constants for the dual converter serial word decoder
package dac_word_pkg;

   // ****************************************************************
   // frame layout
   // ****************************************************************
   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam int BIT_RW = 23;
   localparam int BIT_ZERO = 22;
   localparam int SEL_HI = 21;
   localparam int SEL_LO = 19;
   localparam int CH_HI = 18;
   localparam int CH_LO = 16;
   localparam int DATA_W = 16;

   // ****************************************************************
   // selects and functions
   // ****************************************************************
   localparam logic [2:0] SEL_CODE = 3'h0;
   localparam logic [2:0] SEL_RANGE = 3'h1;
   localparam logic [2:0] SEL_POWER = 3'h2;
   localparam logic [2:0] SEL_CONTROL = 3'h3;
   localparam logic [2:0] CH_A = 3'h0;
   localparam logic [2:0] CH_B = 3'h2;
   localparam logic [2:0] CH_BOTH = 3'h4;
   localparam logic [2:0] CTL_NOP = 3'h0;
   localparam logic [2:0] CTL_CONFIG = 3'h1;
   localparam logic [2:0] CTL_CLEAR = 3'h4;
   localparam logic [2:0] CTL_LOAD = 3'h5;

   // ****************************************************************
   // codes and ranges
   // ****************************************************************
   localparam int CODE_BITS = 12;
   localparam logic [15:0] CODE_MASK = 16'hFFFF << (DATA_W - CODE_BITS);
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [15:0] CLR_ZERO_CODE = 16'h0000;
   localparam logic [15:0] CLR_MID_CODE = 16'h8000;
   localparam logic [2:0] RANGE_RESET = 3'h0;
   localparam logic [2:0] RANGE_BIP_MIN = 3'h3;
   localparam logic [2:0] RANGE_MAX = 3'h5;
   localparam logic [CODE_BITS:0] STEP_RESET = 13'h0000;
   localparam logic [CODE_BITS:0] STEP_BIP_TOP = 13'h07FF;
   localparam logic [CODE_BITS:0] STEP_BIP_BOT = 13'h1800;
   localparam logic [CODE_BITS:0] STEP_UNI_TOP = 13'h0FFF;

   // ****************************************************************
   // control and power words
   // ****************************************************************
   localparam int CFG_SDO_DIS = 0;
   localparam int CFG_CLR_SEL = 1;
   localparam int CFG_CLAMP = 2;
   localparam int CFG_TSD = 3;
   localparam logic [3:0] CFG_RESET = 4'h4;
   localparam int PWR_PU_A = 0;
   localparam int PWR_PU_B = 2;
   localparam logic [15:0] PWR_MASK = 16'h0005;
   localparam logic [15:0] PWR_RESET = 16'h0000;
   localparam logic [23:0] RB_RESET = 24'h000000;

endpackage

/* src/code_store.sv */
// held conversion codes for both channels
`timescale 1ns/1ns
`default_nettype none
module code_store
   import dac_word_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [1:0] we,
   input wire logic [15:0] wdata,
   output logic [15:0] held_a,
   output logic [15:0] held_b
);

   logic [15:0] held_ff [2];

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         held_ff[0] <= CODE_RESET;
         held_ff[1] <= CODE_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (we[i]) begin
               held_ff[i] <= wdata;
            end
         end
      end
   end

   assign held_a = held_ff[0];
   assign held_b = held_ff[1];

endmodule
`default_nettype wire

/* src/frame_shifter.sv */
// link side shift registers on the serial clock
`timescale 1ns/1ns
`default_nettype none
module frame_shifter
   import dac_word_pkg::*;
(
   input wire logic sclk_link,
   input wire logic arst_n,
   input wire logic frame_n,
   input wire logic serial_data_in,
   input wire logic [23:0] rb_word,
   input wire logic sdo_dis,
   output logic [23:0] frame_word,
   output logic full_tgl,
   output logic long_flag,
   output logic sdo_out,
   output logic sdo_oe
);

   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FRAME_BITS);
   localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(FRAME_BITS + 1);

   logic link_rst_n;
   logic [CNT_W-1:0] cnt_ff;
   logic [23:0] in_sr_ff;
   logic [22:0] out_sr_ff;
   logic [23:0] hold_ff;
   logic tgl_ff;
   logic long_ff;

   // clock stops between frames, so the idle level clears the count
   assign link_rst_n = arst_n & ~frame_n;

   // ****************************************************************
   // shift in and out
   // ****************************************************************
   always_ff @(posedge sclk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cnt_ff <= '0;
         in_sr_ff <= '0;
         out_sr_ff <= '0;
         sdo_out <= 1'h0;
         sdo_oe <= 1'h0;
      end else begin
         if (cnt_ff != CNT_SAT) begin
            cnt_ff <= cnt_ff + 1'h1;
         end
         in_sr_ff <= {in_sr_ff[22:0], serial_data_in};
         // rb_word and sdo_dis change only between frames and are quiet during a frame
         if (cnt_ff == '0) begin
            sdo_out <= rb_word[23];
            out_sr_ff <= rb_word[22:0];
            sdo_oe <= ~sdo_dis;
         end else begin
            sdo_out <= out_sr_ff[22];
            out_sr_ff <= {out_sr_ff[21:0], 1'h0};
         end
      end
   end

   // ****************************************************************
   // word hand-off
   // ****************************************************************
   always_ff @(posedge sclk_link or negedge arst_n) begin
      if (!arst_n) begin
         hold_ff <= RB_RESET;
         tgl_ff <= 1'h0;
      end else if (!frame_n && cnt_ff == CNT_LAST) begin
         hold_ff <= {in_sr_ff[22:0], serial_data_in};
         tgl_ff <= ~tgl_ff;
      end
   end

   always_ff @(posedge sclk_link or negedge arst_n) begin
      if (!arst_n) begin
         long_ff <= 1'h0;
      end else if (!frame_n && cnt_ff == '0) begin
         long_ff <= 1'h0;
      end else if (!frame_n && cnt_ff == CNT_FULL) begin
         long_ff <= 1'h1;
      end
   end

   assign frame_word = hold_ff;
   assign full_tgl = tgl_ff;
   assign long_flag = long_ff;

endmodule
`default_nettype wire

/* dv/serial_host_model.sv */
// host side model driving the serial command link
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
   output logic sclk_link,
   output logic frame_n,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe
);
   // ****************************************************************
   // frame engine
   // ****************************************************************
   logic oe_seen;

   initial begin
      sclk_link = 1'b0;
      frame_n = 1'b1;
      serial_data_in = 1'b1;
      oe_seen = 1'b0;
   end

   // link clock stands still between frames, data idles inverted
   task automatic send(input logic [23:0] w, input int nbits,
      output logic [23:0] rx);
      int i;
      rx = 24'h000000;
      oe_seen = 1'b0;
      #3; // keeps the select edge off the system clock edge
      frame_n = 1'b0;
      #10;
      for (i = 0; i < nbits; i++) begin
         serial_data_in = (i == 1 || i > 23) ? 1'b0 : w[23 - i];
         #8;
         sclk_link = 1'b1;
         #7;
         sclk_link = 1'b0;
         rx = {rx[22:0], serial_data_out};
         oe_seen = oe_seen | serial_data_oe;
      end
      // last edge leads the close by five system periods
      #40;
      frame_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #48;
   endtask
endmodule
`default_nettype wire

/* dv/dac_word_decoder_tb_top.sv */
// self-checking bench for the serial command word decoder
`timescale 1ns/1ns
`default_nettype none
module dac_word_decoder_tb_top;
   import dac_word_pkg::*;
   // ****************************************************************
   // design and host
   // ****************************************************************
   logic clk_sys;
   logic arst_n;
   wire logic sclk_link;
   wire logic frame_n;
   wire logic serial_data_in;
   logic serial_data_out;
   logic serial_data_oe;
   logic [15:0] active_code_a;
   logic [15:0] active_code_b;
   logic [2:0] range_code_a;
   logic [2:0] range_code_b;
   logic [CODE_BITS:0] step_a;
   logic [CODE_BITS:0] step_b;
   logic power_up_a;
   logic power_up_b;
   logic tsd_enable;
   logic clamp_enable;
   logic clear_select;
   logic [23:0] rx;
   int error_cnt;
   int n_compared;

   dac_word_decoder u_dac_word_decoder (.clk_sys(clk_sys),
      .arst_n(arst_n), .sclk_link(sclk_link), .frame_n(frame_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe), .active_code_a(active_code_a),
      .active_code_b(active_code_b), .range_code_a(range_code_a),
      .range_code_b(range_code_b), .step_a(step_a), .step_b(step_b),
      .power_up_a(power_up_a), .power_up_b(power_up_b),
      .tsd_enable(tsd_enable), .clamp_enable(clamp_enable),
      .clear_select(clear_select));

   serial_host_model u_serial_host_model (.sclk_link(sclk_link),
      .frame_n(frame_n), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

   always #4 clk_sys = ~clk_sys;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [23:0] frm(input logic rw,
      input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] d);
      frm = {rw, 1'b0, sel, ch, d};
   endfunction

   task automatic chk(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // the commit lands within five system edges of the close
   task automatic wr(input logic [23:0] w, input int n);
      u_serial_host_model.send(w, n, rx);
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic print_verdict;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      chk("active_a", 24'h0, 24'(active_code_a));
      chk("range_b", 24'h0, 24'(range_code_b));
      chk("clamp", 24'h1, 24'(clamp_enable));
      chk("oe", 24'h0, 24'(serial_data_oe));
   endtask

   task automatic t_code;
      wr(frm(1'b0, SEL_CODE, CH_A, 16'h123F), 24);
      chk("active_a", 24'h0, 24'(active_code_a));
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 24);
      chk("active_a", 24'h001230, 24'(active_code_a));
      chk("active_b", 24'h0, 24'(active_code_b));
      chk("step_a", 24'h000123, 24'(step_a));
      wr(frm(1'b0, SEL_CODE, CH_B, 16'hFFF9), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 24);
      chk("step_b", 24'h000FFF, 24'(step_b));
   endtask

   task automatic t_bipolar;
      wr(frm(1'b0, SEL_RANGE, CH_BOTH, 16'hFFFB), 24);
      chk("range_a", 24'h3, 24'(range_code_a));
      chk("range_b", 24'h3, 24'(range_code_b));
      wr(frm(1'b0, SEL_CODE, CH_B, 16'h800F), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 24);
      chk("step_b", 24'h001800, 24'(step_b));
      chk("active_a", 24'h001230, 24'(active_code_a));
      wr(frm(1'b0, SEL_CODE, CH_BOTH, 16'h7FF0), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 24);
      chk("step_a", 24'h0007FF, 24'(step_a));
      chk("step_b", 24'h0007FF, 24'(step_b));
   endtask

   task automatic t_ranges;
      int r;
      for (r = 0; r < 6; r++) begin
         wr(frm(1'b0, SEL_RANGE, CH_B, 16'(r)), 24);
         chk("range_b", 24'(r), 24'(range_code_b));
      end
      wr(frm(1'b0, SEL_RANGE, CH_B, 16'h0006), 24);
      chk("range_b", 24'h5, 24'(range_code_b));
      wr(frm(1'b0, SEL_RANGE, 3'h1, 16'h0000), 24);
      chk("range_a", 24'h3, 24'(range_code_a));
   endtask

   task automatic t_partial;
      wr(frm(1'b0, SEL_CODE, CH_A, 16'hABC0), 23);
      wr(frm(1'b0, SEL_CODE, CH_A, 16'hABC0), 25);
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 24);
      chk("active_a", 24'h007FF0, 24'(active_code_a));
      wr(frm(1'b0, SEL_CONTROL, CTL_LOAD, 16'h0000), 23);
      chk("step_a", 24'h0007FF, 24'(step_a));
   endtask

   task automatic t_ctrl;
      wr(frm(1'b0, SEL_POWER, CH_A, 16'h0005), 24);
      chk("power", 24'h3, 24'({power_up_a, power_up_b}));
      wr(frm(1'b0, SEL_CONTROL, CTL_CONFIG, 16'h000E), 24);
      chk("cfg", 24'h7, 24'({tsd_enable, clamp_enable, clear_select}));
      wr(frm(1'b0, SEL_CONTROL, CTL_CLEAR, 16'h0000), 24);
      chk("active_b", 24'h008000, 24'(active_code_b));
      wr(frm(1'b0, SEL_CONTROL, CTL_CONFIG, 16'h0000), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_CLEAR, 16'h0000), 24);
      chk("active_a", 24'h0, 24'(active_code_a));
   endtask

   task automatic t_read;
      wr(frm(1'b1, SEL_RANGE, CH_A, 16'h0000), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_NOP, 16'h0000), 24);
      chk("readback", 24'h880003, rx);
      chk("oe_seen", 24'h1, 24'(u_serial_host_model.oe_seen));
      chk("range_a", 24'h3, 24'(range_code_a));
      wr(frm(1'b0, SEL_CONTROL, CTL_CONFIG, 16'h0001), 24);
      wr(frm(1'b0, SEL_CONTROL, CTL_NOP, 16'h0000), 24);
      chk("oe_seen", 24'h0, 24'(u_serial_host_model.oe_seen));
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      arst_n = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      rx = 24'h000000;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_code();
      t_bipolar();
      t_ranges();
      t_partial();
      t_ctrl();
      t_read();
      print_verdict();
   end

   // a hang counts as a mismatch
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
